// ### testbench/ccs_clock_switcher_checker.sv
`default_nettype none
module ccs_clock_switcher_checker
(
  input wire logic                           clk,
  input wire logic                           rst_n,
  input wire logic [ccs_pkg::ADDR_W-1:0]     regAddr,
  input wire logic [ccs_pkg::DATA_W-1:0]     regWdata,
  input wire logic                           regWr,
  input wire logic                           regRd,
  input wire logic [ccs_pkg::DATA_W-1:0]     regRdata,
  input wire logic                           haltReq,
  input wire logic                           cpuClkTick,
  input wire logic                           cpuRun,
  input wire logic                           cpuSourceStatus,
  input wire logic                           mainOscRun,
  input wire logic                           sub2OscRun,
  input wire logic [ccs_pkg::SUB2_UNITS-1:0] sub2PeriphTick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_quiet: assert property (
    $rose(rst_n) |-> !mainOscRun && !cpuRun && !cpuSourceStatus)
    else $error("outputs not quiet after reset");
  chk_osc_start: assert property (
    $rose(rst_n) |=> mainOscRun)
    else $error("main oscillator did not start");
  chk_status_read: assert property (
    regRd && regAddr == ccs_pkg::ADDR_CPU_CLOCK_CONTROL
    |=> regRdata[5] == $past(cpuSourceStatus))
    else $error("status bit read wrong");
  chk_rdata_idle: assert property (
    !regRd |=> regRdata == '0)
    else $error("read data not zero when idle");
  chk_fixed_zero: assert property (
    regRd |=> !regRdata[6] && !regRdata[3])
    else $error("fixed zero bit read as one");
  chk_stab_notick: assert property (
    !cpuRun |-> !cpuClkTick)
    else $error("CPU clock before stabilisation");
  chk_halt_gate: assert property (
    haltReq && $past(haltReq) |-> !cpuClkTick)
    else $error("CPU clock during halt");
  chk_sub2_gate: assert property (
    !sub2OscRun && !$past(sub2OscRun) |-> sub2PeriphTick == '0)
    else $error("sub2 tick while gated");
  chk_sub2_units: assert property (
    sub2PeriphTick != '0 |-> &sub2PeriphTick && $past(sub2OscRun))
    else $error("sub2 units disagree");
  chk_main_keep: assert property (
    mainOscRun && !cpuSourceStatus |=> mainOscRun)
    else $error("main stopped while it clocks the CPU");

  cover property ($rose(cpuSourceStatus));
  cover property ($fell(cpuSourceStatus));
  cover property (haltReq && sub2PeriphTick != '0);
  cover property ($fell(mainOscRun));
endmodule

bind ccs_clock_switcher ccs_clock_switcher_checker
  ccs_clock_switcher_checker_i (.clk, .rst_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .haltReq, .cpuClkTick, .cpuRun, .cpuSourceStatus,
  .mainOscRun, .sub2OscRun, .sub2PeriphTick);
`default_nettype wire

// ### testbench/ccs_clock_switcher_tb.sv
`default_nettype none
module ccs_clock_switcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           clk = 1'b0;
  logic                           rst_n = 1'b0;
  logic [ccs_pkg::ADDR_W-1:0]     regAddr = '0;
  logic [ccs_pkg::DATA_W-1:0]     regWdata = '0;
  logic [ccs_pkg::DATA_W-1:0]     regRdata;
  logic                           regWr = 1'b0;
  logic                           regRd = 1'b0;
  logic                           mainClkIn = 1'b0;
  logic                           sub1ClkIn = 1'b0;
  logic                           sub2ClkIn = 1'b0;
  logic                           haltReq = 1'b0;
  logic                           cpuClkTick, cpuRun, cpuSourceStatus;
  logic                           mainOscRun, sub2OscRun, sub1PeriphTick;
  logic [ccs_pkg::SUB2_UNITS-1:0] sub2PeriphTick;
  logic [7:0]                     model [2];
  logic                           es;
  int                             err_count = 0;
  int                             compares = 0;
  int                             pc = 0;
  int                             k, s, t, d;

  ccs_clock_switcher #(.STAB_SUB1_CYCLES(4)) ccs_clock_switcher_i
  (
    .clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .mainClkIn, .sub1ClkIn, .sub2ClkIn, .haltReq, .cpuClkTick, .cpuRun,
    .cpuSourceStatus, .mainOscRun, .sub2OscRun, .sub1PeriphTick,
    .sub2PeriphTick
  );

  initial forever #12.5 clk = ~clk;

  // Oscillator pins stand still while their oscillator is disabled.
  always @(posedge clk)
  begin
    pc <= pc + 1;
    if (pc % 10 == 9) sub1ClkIn <= ~sub1ClkIn;
    if (pc % 2 == 1 && mainOscRun === 1'b1) mainClkIn <= ~mainClkIn;
    if (pc % 3 == 2 && sub2OscRun === 1'b1) sub2ClkIn <= ~sub2ClkIn;
  end

  task report_and_stop;
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task rng(input int g, input int e);
    compares++;
    if (g < e - 1 || g > e + 1)
    begin
      err_count++;
      $display("BAD %0t count %0d exp %0d", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    if (a == 4'h0) model[0] = v & 8'h97;
    if (a == 4'h1) model[1] = v & 8'h01;
  endtask

  task rc(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, a > 4'h1 ? 8'h00 :
        model[a] | (a == 4'h0 ? {2'h0, es, 5'h0} : 8'h00));
  endtask

  task cnt(input int n);
    k = 0;
    s = 0;
    t = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (cpuClkTick === 1'b1) k++;
      if (sub1PeriphTick === 1'b1) s++;
      if (sub2PeriphTick[0] === 1'b1) t++;
    end
  endtask

  task ws(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && cpuSourceStatus !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, cpuSourceStatus}, {7'h0, v});
    if (i == lim) report_and_stop;
  endtask

  initial
  begin
    void'($urandom(32'he283));
    model[0] = 8'h04;
    model[1] = 8'h00;
    es = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (d = 0; d < 400 && cpuRun !== 1'b1; d++) @(posedge clk);
    chk({7'h0, cpuRun}, 8'h01);
    if (d == 400) report_and_stop;
    rc(4'h0);
    rc(4'h1);
    rc(4'h9);
    cnt(192);
    rng(k, 3);
    for (d = 0; d < 3; d++)
    begin
      wr(4'h0, d[7:0]);
      repeat (200) @(posedge clk);
      cnt(192);
      rng(k, 48 >> d);
    end
    wr(4'h0, 8'h4a);
    rc(4'h0);
    wr(4'h0, 8'h12);
    es = 1'b1;
    ws(1'b1, 160);
    rc(4'h0);
    wr(4'h0, 8'h11);
    cnt(200);
    rng(k, 10);
    wr(4'h0, 8'h91);
    repeat (3) @(posedge clk);
    chk({7'h0, mainOscRun}, 8'h00);
    wr(4'h1, 8'h01);
    haltReq <= 1'b1;
    repeat (2) @(posedge clk);
    cnt(120);
    rng(k, 0);
    rng(s, 6);
    rng(t, 20);
    haltReq <= 1'b0;
    wr(4'h0, 8'h11);
    repeat (3) @(posedge clk);
    chk({7'h0, mainOscRun}, 8'h01);
    wr(4'h0, 8'h00);
    es = 1'b0;
    ws(1'b0, 70);
    cnt(192);
    rng(k, 48);
    haltReq <= 1'b1;
    repeat (2) @(posedge clk);
    cnt(60);
    rng(k, 0);
    haltReq <= 1'b0;
    repeat (6)
    begin
      wr(4'h1, 8'($urandom));
      rc(4'h1);
    end
    wr(4'h1, 8'h00);
    repeat (2) @(posedge clk);
    cnt(60);
    rng(t, 0);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h0, mainOscRun}, 8'h00);
    rst_n <= 1'b1;
    model[0] = 8'h04;
    model[1] = 8'h00;
    rc(4'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### verilog/ccs_clock_switcher.sv
// How it works
// R1: Reset loads the control register with 04H, main clock divided by 16.
// R2: The main oscillator is held stopped while reset is low.
// R3: Software sets division 00H, 01H or 02H before using subsystem clock 1.
// R4: On the main clock the CPU clock follows the three-bit division field.
// R5: Halt may be entered while the main clock drives the CPU.
// R6: On subsystem clock 1 software may stop the main oscillator; halt works.
// R7: Subsystem clock 1 and 2 peripheral clocks keep running during halt.
// R8: Subsystem clock 2 has its own gate and feeds four peripherals only.
// R9: A read-only status bit shows the source that actually clocks the CPU.
// R10: On subsystem clock 1 the division field has no effect.
// R11: Writes to the division bits or source select start a switchover.
// R12: The switch completes after a bounded number of old-clock instructions.
// R13: Software keeps division unchanged in a write that selects sub clock 1.
// R14: One write may change division and return to the main clock together.
// R15: After reset a wait timed from sub clock 1 precedes execution.
// R16: Software sets source select first, and only then the stop bit.
// R17: Software clears the oscillator stop bit first, then the source select.
// R18: A restarted main oscillator needs no wait beyond its first clock edge.
// R19: Stop bit 7, status bit 5, select bit 4, division bits 2..0; 6, 3 zero.
// R20: Software sees the status bit at one before stopping the main clock.
// R21: Software never changes select and stop bits in one write.
// R22: Subsystem clock 2 runs while its bit is one; restart has no wait.
// R23: The status bit changes exactly at the cycle the handover completes.
`default_nettype none
module ccs_clock_switcher
#(
  parameter int unsigned STAB_SUB1_CYCLES = ccs_pkg::STAB_SUB1_CYCLES
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [ccs_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [ccs_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [ccs_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                        mainClkIn,
  input  wire logic                        sub1ClkIn,
  input  wire logic                        sub2ClkIn,
  input  wire logic                        haltReq,
  output logic                             cpuClkTick,
  output logic                             cpuRun,
  output logic                             cpuSourceStatus,
  output logic                             mainOscRun,
  output logic                             sub2OscRun,
  output logic                             sub1PeriphTick,
  output logic      [ccs_pkg::SUB2_UNITS-1:0] sub2PeriphTick
);

  // Mask of the divider counter for a division field; prohibited codes
  // above the slowest ratio fall back to the slowest ratio.
  function automatic logic [ccs_pkg::DIVCNT_W-1:0] divMask
  (
    input logic [ccs_pkg::DIV_W-1:0] divSel
  );
    logic [ccs_pkg::DIV_W-1:0]    useDiv;
    logic [ccs_pkg::DIVCNT_W:0]   ratio;
    useDiv = (divSel > ccs_pkg::DIV_MAX) ? ccs_pkg::DIV_MAX : divSel;
    ratio  = (ccs_pkg::DIVCNT_W+1)'(1) << useDiv;
    return ccs_pkg::DIVCNT_W'(ratio - (ccs_pkg::DIVCNT_W+1)'(1));
  endfunction

  logic [ccs_pkg::SRC_NUM-1:0] srcPins;
  logic [ccs_pkg::SRC_NUM-1:0] srcEdge;
  logic                        mainEdge;
  logic                        sub1Edge;
  logic                        sub2Edge;

  assign srcPins[ccs_pkg::SRC_MAIN] = mainClkIn;
  assign srcPins[ccs_pkg::SRC_SUB1] = sub1ClkIn;
  assign srcPins[ccs_pkg::SRC_SUB2] = sub2ClkIn;

  genvar gs;
  generate
    for (gs = 0; gs < ccs_pkg::SRC_NUM; gs++)
    begin : g_sync
      ccs_edge_sync u_sync
      (
        .clk       (clk),
        .rst_n     (rst_n),
        .pinIn     (srcPins[gs]),
        .risePulse (srcEdge[gs])
      );
    end
  endgenerate

  assign mainEdge = srcEdge[ccs_pkg::SRC_MAIN];
  assign sub1Edge = srcEdge[ccs_pkg::SRC_SUB1];
  assign sub2Edge = srcEdge[ccs_pkg::SRC_SUB2];

  // Register file.
  logic [ccs_pkg::DATA_W-1:0] ctl_q;
  logic [ccs_pkg::DATA_W-1:0] ctl_d;
  logic [ccs_pkg::DATA_W-1:0] gate_q;
  logic [ccs_pkg::DATA_W-1:0] gate_d;
  logic [ccs_pkg::DATA_W-1:0] rdata_q;
  logic [ccs_pkg::DATA_W-1:0] rdata_d;

  // Switchover engine.
  ccs_pkg::ccs_state_t            state_q;
  ccs_pkg::ccs_state_t            state_d;
  logic [ccs_pkg::STAB_CNT_W-1:0] stabCnt_q;
  logic [ccs_pkg::STAB_CNT_W-1:0] stabCnt_d;
  logic [ccs_pkg::OLD_TICK_W-1:0] oldCnt_q;
  logic [ccs_pkg::OLD_TICK_W-1:0] oldCnt_d;
  logic                           activeSrc_q;
  logic                           activeSrc_d;
  logic [ccs_pkg::DIV_W-1:0]      activeDiv_q;
  logic [ccs_pkg::DIV_W-1:0]      activeDiv_d;
  logic [ccs_pkg::DIVCNT_W-1:0]   divCnt_q;
  logic [ccs_pkg::DIVCNT_W-1:0]   divCnt_d;

  // Output flops.
  logic                           cpuTick_q;
  logic                           cpuTick_d;
  logic                           cpuRun_q;
  logic                           cpuRun_d;
  logic                           mainOsc_q;
  logic                           mainOsc_d;
  logic                           sub1Tick_q;
  logic                           sub1Tick_d;
  logic [ccs_pkg::SUB2_UNITS-1:0] sub2Tick_q;
  logic [ccs_pkg::SUB2_UNITS-1:0] sub2Tick_d;

  logic                      selSub1;
  logic [ccs_pkg::DIV_W-1:0] selDiv;
  logic                      divTick;
  logic                      oldTick;
  logic                      mismatch;

  assign selSub1 = ctl_q[ccs_pkg::SOURCE_SELECT_BIT];
  assign selDiv  = ctl_q[ccs_pkg::DIV_LSB +: ccs_pkg::DIV_W];
  assign divTick = mainEdge & (divCnt_q == divMask(activeDiv_q)); // R4
  assign oldTick = activeSrc_q ? sub1Edge : divTick;
  // The division field only matters while the main clock is wanted.
  assign mismatch = (selSub1 != activeSrc_q) ||
                    (!selSub1 && (selDiv != activeDiv_q)); // R10 R11 R14

  always_comb
  begin
    ctl_d   = ctl_q;
    gate_d  = gate_q;
    rdata_d = '0;
    if (regWr && (regAddr == ccs_pkg::ADDR_CPU_CLOCK_CONTROL))
    begin
      ctl_d = regWdata & ccs_pkg::CPU_CLOCK_CONTROL_WMASK; // R19
    end
    if (regWr && (regAddr == ccs_pkg::ADDR_SUB2_CLOCK_GATE))
    begin
      gate_d = regWdata & ccs_pkg::SUB2_CLOCK_GATE_WMASK; // R22
    end
    if (regRd)
    begin
      case (regAddr)
        ccs_pkg::ADDR_CPU_CLOCK_CONTROL:
        begin
          rdata_d = ctl_q;
          rdata_d[ccs_pkg::SOURCE_STATUS_BIT] = activeSrc_q; // R9
        end
        ccs_pkg::ADDR_SUB2_CLOCK_GATE:
        begin
          rdata_d = gate_q;
        end
        default:
        begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_q   <= ccs_pkg::CPU_CLOCK_CONTROL_RESET; // R1
      gate_q  <= ccs_pkg::SUB2_CLOCK_GATE_RESET;
      rdata_q <= '0;
    end
    else
    begin
      ctl_q   <= ctl_d;
      gate_q  <= gate_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb
  begin
    state_d     = state_q;
    stabCnt_d   = stabCnt_q;
    oldCnt_d    = oldCnt_q;
    activeSrc_d = activeSrc_q;
    activeDiv_d = activeDiv_q;
    cpuRun_d    = cpuRun_q;
    divCnt_d    = divCnt_q;
    if (mainEdge)
    begin
      divCnt_d = divTick ? '0 : divCnt_q + 1'b1;
    end
    case (state_q)
      ccs_pkg::ST_STAB:
      begin
        // The CPU stays stopped until the main oscillator has settled.
        if (sub1Edge)
        begin
          stabCnt_d = stabCnt_q + 1'b1;
          if (stabCnt_q == ccs_pkg::STAB_CNT_W'(STAB_SUB1_CYCLES - 1))
          begin
            state_d  = ccs_pkg::ST_RUN; // R15
            cpuRun_d = 1'b1;
          end
        end
      end
      ccs_pkg::ST_RUN:
      begin
        if (mismatch)
        begin
          state_d  = ccs_pkg::ST_WAIT_OLD; // R11
          oldCnt_d = '0;
        end
      end
      ccs_pkg::ST_WAIT_OLD:
      begin
        // The old clock keeps running for one shortest instruction.
        if (!mismatch)
        begin
          state_d = ccs_pkg::ST_RUN;
        end
        else if (oldTick)
        begin
          oldCnt_d = oldCnt_q + 1'b1;
          if (oldCnt_q == ccs_pkg::SWITCH_OLD_TICKS - 1'b1)
          begin
            state_d = ccs_pkg::ST_WAIT_NEW; // R12
          end
        end
      end
      ccs_pkg::ST_WAIT_NEW:
      begin
        // The handover happens on an edge of the new source so that no
        // shortened CPU clock period is ever produced.
        if (!mismatch)
        begin
          state_d = ccs_pkg::ST_RUN;
        end
        else if (selSub1 && sub1Edge)
        begin
          activeSrc_d = 1'b1; // R23
          state_d     = ccs_pkg::ST_RUN;
        end
        else if (!selSub1 && mainEdge && mainOsc_q)
        begin
          activeSrc_d = 1'b0; // R18 R23
          activeDiv_d = selDiv; // R14
          divCnt_d    = '0;
          state_d     = ccs_pkg::ST_RUN;
        end
      end
      default:
      begin
        state_d = ccs_pkg::ST_STAB;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q     <= ccs_pkg::ST_STAB;
      stabCnt_q   <= '0;
      oldCnt_q    <= '0;
      activeSrc_q <= 1'b0;
      activeDiv_q <= ccs_pkg::CPU_CLOCK_CONTROL_RESET[ccs_pkg::DIV_W-1:0];
      divCnt_q    <= '0;
      cpuRun_q    <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      stabCnt_q   <= stabCnt_d;
      oldCnt_q    <= oldCnt_d;
      activeSrc_q <= activeSrc_d;
      activeDiv_q <= activeDiv_d;
      divCnt_q    <= divCnt_d;
      cpuRun_q    <= cpuRun_d;
    end
  end

  always_comb
  begin
    // Halt gates only the CPU clock; the source keeps being counted.
    cpuTick_d = cpuRun_q && !haltReq && (state_q != ccs_pkg::ST_WAIT_NEW) &&
                oldTick; // R5 R6 R10
    // The oscillator may stop only once subsystem clock 1 drives the CPU.
    mainOsc_d = !(ctl_q[ccs_pkg::MAIN_OSC_STOP_BIT] && activeSrc_q); // R6 R20
    sub1Tick_d = sub1Edge; // R7
  end

  genvar gu;
  generate
    for (gu = 0; gu < ccs_pkg::SUB2_UNITS; gu++)
    begin : g_sub2
      assign sub2Tick_d[gu] = sub2Edge & gate_q[ccs_pkg::SUB2_RUN_BIT]; // R8
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cpuTick_q  <= 1'b0;
      mainOsc_q  <= 1'b0; // R2
      sub1Tick_q <= 1'b0;
      sub2Tick_q <= '0;
    end
    else
    begin
      cpuTick_q  <= cpuTick_d;
      mainOsc_q  <= mainOsc_d; // R15
      sub1Tick_q <= sub1Tick_d;
      sub2Tick_q <= sub2Tick_d;
    end
  end

  assign regRdata        = rdata_q;
  assign cpuClkTick      = cpuTick_q;
  assign cpuRun          = cpuRun_q;
  assign cpuSourceStatus = activeSrc_q; // R9
  assign mainOscRun      = mainOsc_q;
  assign sub2OscRun      = gate_q[ccs_pkg::SUB2_RUN_BIT]; // R22
  assign sub1PeriphTick  = sub1Tick_q;
  assign sub2PeriphTick  = sub2Tick_q;

endmodule
`default_nettype wire

// ### verilog/ccs_edge_sync.sv
`default_nettype none
// Two-stage synchroniser for an oscillator pin with a rising-edge pulse.
module ccs_edge_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      risePulse
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;
  logic rise_q;
  logic rise_d;

  always_comb
  begin
    meta_d = pinIn;
    sync_d = meta_q;
    prev_d = sync_q;
    rise_d = sync_q & ~prev_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // A high reset level keeps a pin that is already high at release
      // from producing a false rising edge.
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
      rise_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      rise_q <= rise_d;
    end
  end

  assign risePulse = rise_q;

endmodule
`default_nettype wire

// ### verilog/ccs_pkg.sv
`default_nettype none
package ccs_pkg;

  // Register port geometry and register placement.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CPU_CLOCK_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SUB2_CLOCK_GATE   = 4'h1;

  // Reset values.
  localparam logic [DATA_W-1:0] CPU_CLOCK_CONTROL_RESET = 8'h04;
  localparam logic [DATA_W-1:0] SUB2_CLOCK_GATE_RESET   = 8'h00;

  // Field positions of the CPU clock control register.
  localparam int unsigned MAIN_OSC_STOP_BIT = 7;
  localparam int unsigned SOURCE_STATUS_BIT = 5;
  localparam int unsigned SOURCE_SELECT_BIT = 4;
  localparam int unsigned DIV_LSB           = 0;
  localparam int unsigned DIV_W             = 3;
  // Field position of the subsystem clock 2 gate register.
  localparam int unsigned SUB2_RUN_BIT      = 0;

  // Bits that software can store; bits 6, 5 and 3 always hold zero.
  localparam logic [DATA_W-1:0] CPU_CLOCK_CONTROL_WMASK = 8'h97;
  localparam logic [DATA_W-1:0] SUB2_CLOCK_GATE_WMASK   = 8'h01;

  // Main clock divider: ratio is two to the power of the field.
  localparam int unsigned       DIVCNT_W = 4;
  localparam logic [DIV_W-1:0]  DIV_MAX  = 3'h4;

  // Old-clock cycles run before a handover: one shortest instruction.
  localparam int unsigned      OLD_TICK_W       = 2;
  localparam logic [OLD_TICK_W-1:0] SWITCH_OLD_TICKS = 2'h2;

  // Oscillation stabilisation after reset, timed in subsystem clock 1.
  localparam int unsigned STAB_TIME_MS     = 250;
  localparam int unsigned SUB1_FREQ_HZ     = 32768;
  localparam int unsigned MS_PER_S         = 1000;
  localparam int unsigned STAB_SUB1_CYCLES =
    STAB_TIME_MS * SUB1_FREQ_HZ / MS_PER_S;
  localparam int unsigned STAB_CNT_W       = 14;

  // Source pin indexes for the edge synchronisers.
  localparam int unsigned SRC_MAIN = 0;
  localparam int unsigned SRC_SUB1 = 1;
  localparam int unsigned SRC_SUB2 = 2;
  localparam int unsigned SRC_NUM  = 3;

  // Peripheral units that may receive subsystem clock 2.
  localparam int unsigned UNIT_TIMER16      = 0;
  localparam int unsigned UNIT_SAMPLING_DET = 1;
  localparam int unsigned UNIT_SYNC_SERIAL  = 2;
  localparam int unsigned UNIT_ASYNC_SERIAL = 3;
  localparam int unsigned SUB2_UNITS        = 4;

  typedef enum logic [1:0]
  {
    ST_STAB     = 2'b00,
    ST_RUN      = 2'b01,
    ST_WAIT_OLD = 2'b10,
    ST_WAIT_NEW = 2'b11
  } ccs_state_t;

endpackage
`default_nettype wire
